//--- pkg/ubg_cfg.svh
/*
  constants for the serial baud rate generator: register offsets, fields,
  reset values and prescale ratios.
  assumes it is included by bare name from design and testbench files.
*/
`ifndef UBG_CFG_SVH
`define UBG_CFG_SVH

// register byte offsets
`define UBG_OFF_CTRL      12'h000
`define UBG_OFF_RELOAD    12'h004
`define UBG_OFF_COUNT     12'h008
`define UBG_OFF_STATUS    12'h00c

// control register field positions
`define UBG_CTRL_RUN      0
`define UBG_CTRL_GATE     1
`define UBG_CTRL_GPOL     2
`define UBG_CTRL_T1M      3
`define UBG_CTRL_SCA_LO   4
`define UBG_CTRL_SCA_HI   5
`define UBG_CTRL_EXTIN    6

// status register field positions
`define UBG_STAT_OVF      0
`define UBG_STAT_TXB      1
`define UBG_STAT_RXB      2
`define UBG_STAT_EN       3

// reset values
`define UBG_CTRL_RST      7'h00
`define UBG_BYTE_RST      8'h00

// prescale ratios
`define UBG_DIV4          4
`define UBG_DIV12         12
`define UBG_DIV48         48
`define UBG_DIV_EXT       8

`endif

//--- pkg/ubg_pkg.sv
/*
  types for the serial baud rate generator.
  assumes ubg_cfg.svh sits beside it.
*/
package ubg_pkg;
  // timer clock source codes, two-bit prescale select
  typedef enum logic [1:0] {
    UBG_SCA_DIV12 = 2'b00,
    UBG_SCA_DIV4  = 2'b01,
    UBG_SCA_DIV48 = 2'b10,
    UBG_SCA_EXT8  = 2'b11
  } ubg_sca_t;

  // start detector states
  typedef enum logic [1:0] {
    UBG_ST_IDLE  = 2'b00,
    UBG_ST_ARMED = 2'b01,
    UBG_ST_BUSY  = 2'b10
  } ubg_start_t;
endpackage

//--- pkg/ubg_tick_if.sv
/*
  interface carrying timer clock ticks between the prescaler and the core.
  assumes one clock domain, clk_sys.
*/
`timescale 1ns/1ps
interface ubg_tick_if;
  logic tick_sys;    // undivided system clock tick
  logic tick_div4;   // one pulse per 4 clocks
  logic tick_div12;  // one pulse per 12 clocks
  logic tick_div48;  // one pulse per 48 clocks
  logic tick_ext8;   // one pulse per 8 external oscillator rising edges
  logic tick_pin;    // one pulse per external input rising edge
  modport src (output tick_sys, tick_div4, tick_div12, tick_div48, tick_ext8, tick_pin);
  modport dst (input  tick_sys, tick_div4, tick_div12, tick_div48, tick_ext8, tick_pin);
endinterface

//--- core/ubg_prescaler.sv
/*
  prescaler: builds one-cycle enable pulses for every timer clock choice.
  assumes the external oscillator and external input are already synchronised.
*/
`timescale 1ns/1ps
`include "ubg_cfg.svh"
module ubg_prescaler (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic ext_osc_s,  // synchronised external oscillator level
  input  wire logic ext_pin_s,  // synchronised external count input
  ubg_tick_if.src   ticks
);
  import ubg_pkg::*;

  logic [5:0] div_cnt_r;  // shared system clock divider
  logic [2:0] ext_cnt_r;  // oscillator rising edges, wraps at 8
  logic       ext_d_r;    // previous external oscillator level
  logic       pin_d_r;    // previous external input level

  // one counter serves all three ratios, 48 being a multiple of 4 and 12
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_cnt_r <= 6'h00;
    end else if (div_cnt_r == 6'(`UBG_DIV48 - 1)) begin
      div_cnt_r <= 6'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 6'h01;
    end
  end

  // edge history of the synchronised inputs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ext_d_r <= 1'b0;
      pin_d_r <= 1'b0;
    end else begin
      ext_d_r <= ext_osc_s;
      pin_d_r <= ext_pin_s;
    end
  end

  // divide by 8: one tick per eight full oscillator periods (rising edges)
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ext_cnt_r <= 3'h0;
    end else if (ext_osc_s && !ext_d_r) begin
      ext_cnt_r <= ext_cnt_r + 3'h1;
    end
  end

  assign ticks.tick_sys   = 1'b1;
  assign ticks.tick_div4  = (div_cnt_r[1:0] == 2'h3);
  assign ticks.tick_div12 = ((div_cnt_r % 6'(`UBG_DIV12)) == 6'(`UBG_DIV12 - 1));
  assign ticks.tick_div48 = (div_cnt_r == 6'(`UBG_DIV48 - 1));
  assign ticks.tick_ext8  = ext_osc_s && !ext_d_r && (ext_cnt_r == 3'(`UBG_DIV_EXT - 1));
  assign ticks.tick_pin   = ext_pin_s && !pin_d_r;

  // divide by 4 pulses sit exactly four cycles apart
  a_div4_rate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ticks.tick_div4 |=> !ticks.tick_div4 [*3] ##1 ticks.tick_div4)
    else $error("divide by 4 tick spacing wrong");
endmodule

//--- core/ubg_reload_timer.sv
/*
  one 8-bit auto-reload timer with its divide-by-two baud stage.
  assumes count enable and force inputs are on clk_sys.
*/
`timescale 1ns/1ps
module ubg_reload_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             cnt_en,     // one timer clock tick while running
  input  wire logic [WIDTH-1:0] reload,     // reload byte
  input  wire logic             force_ld,   // forced reload, clears baud stage
  input  wire logic             sw_wr,      // software write of the count
  input  wire logic [WIDTH-1:0] sw_data,    // value written by software
  output logic      [WIDTH-1:0] count,      // current count
  output logic                  ovf,        // overflow pulse
  output logic                  baud        // overflow rate halved
);
  // elaboration check: a one-bit timer cannot hold a useful reload
  if (WIDTH < 2) begin
    $error("timer width too small");
  end

  logic [WIDTH-1:0] cnt_r;   // running count
  logic             baud_r;  // toggle stage

  assign ovf   = cnt_en && (cnt_r == {WIDTH{1'b1}});
  assign count = cnt_r;
  assign baud  = baud_r;

  // count, reload on wrap, forced reload and software load
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else if (force_ld) begin
      cnt_r <= reload;
    end else if (sw_wr) begin
      cnt_r <= sw_data;
    end else if (ovf) begin
      cnt_r <= reload;
    end else if (cnt_en) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // toggle on each overflow, halving the rate
  always_ff @(posedge clk_sys) begin
    if (sys_rst || force_ld) begin
      baud_r <= 1'b0;
    end else if (ovf) begin
      baud_r <= ~baud_r;
    end
  end
endmodule

//--- core/ubg_baud_gen.sv
/*
  serial port baud rate generator: timer 1 in 8-bit auto-reload mode drives
  a transmit and a hidden receive timer, each halved into a baud clock.
  assumes an APB master on clk_sys and asynchronous pins from outside.
*/
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "ubg_cfg.svh"
module ubg_baud_gen (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_osc_clock,
  input  wire logic        ext_count_pin,
  input  wire logic        ext_gate_pin,
  input  wire logic        rx_pin,
  output logic             tx_baud,
  output logic             rx_baud,
  output logic             tx_ovf,
  output logic             rx_ovf
);
  import ubg_pkg::*;

  // control and data registers
  logic       timer_run_bit_r;          // run enable
  logic       timer_gate_enable_r;      // gate by external level
  logic       gate_pol_r;               // active level of gate pin
  logic       timer1_core_system_clock_select_r;   // undivided system clock
  ubg_sca_t   timer_prescale_select_r;  // prescale field
  logic       ext_src_r;                // count external input pin
  logic [7:0] timer1_reload_byte_r;     // reload value
  logic       timer_overflow_flag_r;    // sticky overflow flag
  localparam logic [6:0] ctrl_rst_img = `UBG_CTRL_RST;  // control reset image

  // two-flop synchronisers for the pins
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= {rx_pin, ext_gate_pin, ext_count_pin, external_osc_clock};
      sync2_r <= sync1_r;
    end
  end
  wire osc_s  = sync2_r[0];
  wire cpin_s = sync2_r[1];
  wire gate_s = sync2_r[2];
  wire rx_s   = sync2_r[3];

  // tick sources
  ubg_tick_if ticks ();
  ubg_prescaler u_pre (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .ext_osc_s (osc_s),
    .ext_pin_s (cpin_s),
    .ticks     (ticks.src)
  );

  // clock source choice, used by the enable logic
  function automatic logic pick_tick(input logic t1m, input logic ext, input ubg_sca_t sca,
                                     input logic t_sys, input logic t4, input logic t12,
                                     input logic t48, input logic t8, input logic tp);
    if (ext) begin
      pick_tick = tp;
    end else if (t1m) begin
      pick_tick = t_sys;
    end else begin
      case (sca)
        UBG_SCA_DIV12: pick_tick = t12;
        UBG_SCA_DIV4:  pick_tick = t4;
        UBG_SCA_DIV48: pick_tick = t48;
        default:       pick_tick = t8;
      endcase
    end
  endfunction

  wire sel_tick = pick_tick(timer1_core_system_clock_select_r, ext_src_r, timer_prescale_select_r,
                            ticks.tick_sys, ticks.tick_div4, ticks.tick_div12,
                            ticks.tick_div48, ticks.tick_ext8, ticks.tick_pin);

  // run gating: run bit and either no gate or gate pin at active level
  wire timer_en = timer_run_bit_r && (!timer_gate_enable_r || (gate_s == gate_pol_r));
  wire cnt_tick = timer_en && sel_tick;

  // start detector: falling edge of idle-high receive line
  logic       rx_d_r;
  ubg_start_t st_r;
  logic       rx_force_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_d_r <= 1'b1;
    end else begin
      rx_d_r <= rx_s;
    end
  end
  // one force per start; rearm once the line is high again
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r       <= UBG_ST_IDLE;
      rx_force_r <= 1'b0;
    end else begin
      rx_force_r <= 1'b0;
      case (st_r)
        UBG_ST_IDLE: begin
          if (rx_s) st_r <= UBG_ST_ARMED;
        end
        UBG_ST_ARMED: begin
          if (rx_d_r && !rx_s && timer_en) begin
            rx_force_r <= 1'b1;
            st_r       <= UBG_ST_BUSY;
          end
        end
        default: begin
          if (rx_s) st_r <= UBG_ST_ARMED;
        end
      endcase
    end
  end

  // apb decode
  wire acc     = psel && penable;
  wire wr_acc  = acc && pwrite;
  wire rd_acc  = acc && !pwrite;
  wire wr_cnt  = wr_acc && (paddr == `UBG_OFF_COUNT);

  // transmit timer, the software visible low count
  logic [7:0] timer1_low_count;
  logic       tx_ovf_w;
  logic       tx_baud_w;
  ubg_reload_timer #(.WIDTH(8)) u_tx (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .cnt_en   (cnt_tick),
    .reload   (timer1_reload_byte_r),
    .force_ld (1'b0),
    .sw_wr    (wr_cnt),
    .sw_data  (pwdata[7:0]),
    .count    (timer1_low_count),
    .ovf      (tx_ovf_w),
    .baud     (tx_baud_w)
  );

  // hidden receive copy: no software path to it
  logic       rx_ovf_w;
  logic       rx_baud_w;
  logic [7:0] rx_low_count;  // hidden count, watched by assertions only
  ubg_reload_timer #(.WIDTH(8)) u_rx (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .cnt_en   (cnt_tick),
    .reload   (timer1_reload_byte_r),
    .force_ld (rx_force_r),
    .sw_wr    (1'b0),
    .sw_data  (8'h00),
    .count    (rx_low_count),
    .ovf      (rx_ovf_w),
    .baud     (rx_baud_w)
  );

  // register writes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // field by field from the reset image, so the enum keeps its type
      timer_run_bit_r         <= ctrl_rst_img[`UBG_CTRL_RUN];
      timer_gate_enable_r     <= ctrl_rst_img[`UBG_CTRL_GATE];
      gate_pol_r              <= ctrl_rst_img[`UBG_CTRL_GPOL];
      timer1_core_system_clock_select_r  <= ctrl_rst_img[`UBG_CTRL_T1M];
      timer_prescale_select_r <= ubg_sca_t'(ctrl_rst_img[`UBG_CTRL_SCA_HI:`UBG_CTRL_SCA_LO]);
      ext_src_r               <= ctrl_rst_img[`UBG_CTRL_EXTIN];
      timer1_reload_byte_r <= `UBG_BYTE_RST;
    end else if (wr_acc) begin
      if (paddr == `UBG_OFF_CTRL) begin
        timer_run_bit_r         <= pwdata[`UBG_CTRL_RUN];
        timer_gate_enable_r     <= pwdata[`UBG_CTRL_GATE];
        gate_pol_r              <= pwdata[`UBG_CTRL_GPOL];
        timer1_core_system_clock_select_r  <= pwdata[`UBG_CTRL_T1M];
        timer_prescale_select_r <= ubg_sca_t'(pwdata[`UBG_CTRL_SCA_HI:`UBG_CTRL_SCA_LO]);
        ext_src_r               <= pwdata[`UBG_CTRL_EXTIN];
      end else if (paddr == `UBG_OFF_RELOAD) begin
        timer1_reload_byte_r <= pwdata[7:0];
      end
    end
  end

  // overflow flag: set wins over software clear (write 1 to clear)
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      timer_overflow_flag_r <= 1'b0;
    end else if (tx_ovf_w) begin
      timer_overflow_flag_r <= 1'b1;
    end else if (wr_acc && paddr == `UBG_OFF_STATUS && pwdata[`UBG_STAT_OVF]) begin
      timer_overflow_flag_r <= 1'b0;
    end
  end

  // read data and answer, zero wait states
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        if (paddr == `UBG_OFF_CTRL) begin
          prdata <= {25'h0, ext_src_r, timer_prescale_select_r, timer1_core_system_clock_select_r,
                     gate_pol_r, timer_gate_enable_r, timer_run_bit_r};
        end else if (paddr == `UBG_OFF_RELOAD) begin
          prdata <= {24'h0, timer1_reload_byte_r};
        end else if (paddr == `UBG_OFF_COUNT) begin
          prdata <= {24'h0, timer1_low_count};
        end else if (paddr == `UBG_OFF_STATUS) begin
          prdata <= {28'h0, timer_en, rx_baud_w, tx_baud_w, timer_overflow_flag_r};
        end else begin
          pslverr <= 1'b1;  // unmapped address
        end
      end
    end
  end

  // registered baud and overflow outputs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_baud <= 1'b0;
      rx_baud <= 1'b0;
      tx_ovf  <= 1'b0;
      rx_ovf  <= 1'b0;
    end else begin
      tx_baud <= tx_baud_w;
      rx_baud <= rx_baud_w;
      tx_ovf  <= tx_ovf_w;
      rx_ovf  <= rx_ovf_w;
    end
  end

  // assertions
  a_ovf_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tx_ovf_w && !wr_cnt |=> timer1_low_count == $past(timer1_reload_byte_r))
    else $error("low count not reloaded on overflow");
  a_ovf_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tx_ovf_w |=> timer_overflow_flag_r)
    else $error("overflow flag not set");
  a_no_count_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !timer_en && !wr_cnt |=> $stable(timer1_low_count))
    else $error("timer counted while disabled");
  a_tx_halve: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tx_ovf_w |=> tx_baud_w != $past(tx_baud_w))
    else $error("transmit stage did not toggle");
  a_tx_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !tx_ovf_w |=> tx_baud_w == $past(tx_baud_w))
    else $error("transmit stage toggled without overflow");
  sequence s_start_edge;
    rx_d_r && !rx_s && timer_en && st_r == UBG_ST_ARMED;
  endsequence
  a_start_force: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_start_edge |=> rx_force_r ##1 !rx_baud_w)
    else $error("start did not force receive reload");
  a_sys_bypass: assert property (@(posedge clk_sys) disable iff (sys_rst)
    timer1_core_system_clock_select_r && !ext_src_r && timer_en |-> cnt_tick)
    else $error("core_system_clock select did not count every cycle");
  a_gate_block: assert property (@(posedge clk_sys) disable iff (sys_rst)
    timer_gate_enable_r && gate_s != gate_pol_r |-> !cnt_tick)
    else $error("gate did not stop counting");
  a_apb_ready: assert property (@(posedge clk_sys) disable iff (sys_rst)
    psel && !penable |=> pready)
    else $error("no ready in access phase");
  // the hidden copy: same reload, same run gating, own toggle stage
  a_rx_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rx_ovf_w && !rx_force_r |=> rx_low_count == $past(timer1_reload_byte_r))
    else $error("receive copy not reloaded on overflow");
  a_rx_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !timer_en && !rx_force_r |=> $stable(rx_low_count))
    else $error("receive copy counted while disabled");
  a_rx_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !rx_ovf_w && !rx_force_r |=> rx_baud_w == $past(rx_baud_w))
    else $error("receive stage toggled without overflow");
  a_ext_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ext_src_r && timer_en |-> cnt_tick == ticks.tick_pin)
    else $error("external input select did not count pin edges");
endmodule

//--- sim/ubg_serial_far.sv
/*
  far side model: the serial receiver's line, driving start bits.
  assumes clk_sys domain; the receive line idles high.
*/
`timescale 1ns/1ps
module ubg_serial_far (
  input  wire logic clk_sys,
  output logic      rx_pin
);
  // line idles high between frames
  initial begin
    rx_pin = 1'b1;
  end

  // start bit: low for a while, then idle again so the detector rearms
  task automatic start_bit(input int cycles);
    @(posedge clk_sys);
    rx_pin <= 1'b0;
    repeat (cycles) @(posedge clk_sys);
    rx_pin <= 1'b1;
  endtask
endmodule

//--- sim/ubg_baud_gen_tb.sv
/*
  testbench for the baud rate generator: apb tasks, interval checks.
  assumes apb with any number of wait states and registered one-cycle overflow pulses.
*/
`timescale 1ns/1ps
`include "ubg_cfg.svh"
module ubg_baud_gen_tb;
  localparam logic [11:0] a_ctl = `UBG_OFF_CTRL;   // control
  localparam logic [11:0] a_rld = `UBG_OFF_RELOAD; // reload byte
  localparam logic [11:0] a_cnt = `UBG_OFF_COUNT;  // visible count
  localparam logic [11:0] a_st  = `UBG_OFF_STATUS; // status
  logic        clk_sys;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc;      // external oscillator
  logic        ext_cnt;  // external count input
  logic        gate;     // external gate level
  logic        rx_pin;
  logic        tx_baud;
  logic        rx_baud;
  logic        tx_ovf;
  logic        rx_ovf;
  logic        last_err; // pslverr of the last transfer
  logic [31:0] q;
  int          errors;
  int          checked;
  int          n;
  int          divs[4] = '{12, 4, 48, 48}; // cycles per tick; ext: 8 osc periods of 6 cycles

  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // oscillator of 30 ns, offset so it never meets a clock edge
  initial begin
    osc = 1'b0;
    #1.3;
    forever #15 osc = ~osc;
  end

  ubg_baud_gen i_dut (
    .clk_sys            (clk_sys),
    .sys_rst            (sys_rst),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .external_osc_clock (osc),
    .ext_count_pin      (ext_cnt),
    .ext_gate_pin       (gate),
    .rx_pin             (rx_pin),
    .tx_baud            (tx_baud),
    .rx_baud            (rx_baud),
    .tx_ovf             (tx_ovf),
    .rx_ovf             (rx_ovf)
  );

  ubg_serial_far i_far (
    .clk_sys (clk_sys),
    .rx_pin  (rx_pin)
  );

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no assumed latency: only the watchdog ends this wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, q & m, e);
  endtask

  // stop, load reload and count, then start with a control value
  task automatic cfg(input logic [7:0] r, input logic [7:0] c, input logic [7:0] ctl);
    apb(1'b1, a_ctl, 32'h0);
    apb(1'b1, a_rld, 32'(r));
    apb(1'b1, a_cnt, 32'(c));
    apb(1'b1, a_ctl, 32'(ctl));
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return tx_ovf;
      1: return rx_ovf;
      2: return tx_baud;
      default: return rx_baud;
    endcase
  endfunction

  // cycles to next pulse (sel 0,1) or level change (sel 2,3); -1 if none
  task automatic wait_ev(input int sel, input int lim, output int cnt);
    logic p;
    logic c;
    cnt = -1;
    p = pick(sel);
    for (int k = 1; k <= lim && cnt < 0; k++) begin
      @(posedge clk_sys);
      c = pick(sel);
      if ((sel < 2) ? (c === 1'b1) : (c !== p))
        cnt = k;
      p = c;
    end
  endtask

  // steady interval: the first event only sets the phase
  task automatic period(input int sel, input int lim, output int cnt);
    wait_ev(sel, lim, cnt);
    wait_ev(sel, lim, cnt);
  endtask

  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge clk_sys);
      ext_cnt <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_cnt <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask

  // watchdog, far beyond the roughly 2500 cycles the tests need
  initial begin
    repeat (60000) @(posedge clk_sys);
    errors++;
    stop_test();
  end

  initial begin
    errors = 0;
    checked = 0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_cnt = 1'b0;
    gate = 1'b0;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // reset values, readback, unmapped place
    rd("ctrl", a_ctl, 32'hffffffff, 32'h0);
    rd("reload", a_rld, 32'hffffffff, 32'h0);
    rd("count", a_cnt, 32'hffffffff, 32'h0);
    rd("status", a_st, 32'hffffffff, 32'h0);
    apb(1'b1, a_ctl, 32'h7e);
    rd("ctrl back", a_ctl, 32'hffffffff, 32'h7e);
    rd("unmapped", 12'h010, 32'hffffffff, 32'h0);
    check("unmapped err", 32'(last_err), 32'h1);
    $display("test registers done");
    // every prescale code; code 3 counts the oscillator
    for (int i = 0; i < 4; i++) begin
      cfg(8'hff, 8'hff, {2'b00, 2'(i), 4'h1});
      period(0, 200, n);
      check("prescale period", 32'(n), 32'(divs[i]));
    end
    $display("test prescale done");
    // core_system_clock select beats prescale code 11; reload fd gives 3 ticks
    cfg(8'hfd, 8'hfd, 8'h39);
    period(0, 50, n);
    check("core_system_clock period", 32'(n), 32'h3);
    period(2, 50, n);
    check("tx baud half", 32'(n), 32'h3);
    period(1, 300, n);
    check("rx copy period", 32'(n), 32'h3);
    period(3, 50, n);
    check("rx baud half", 32'(n), 32'h3);
    // tx overflow follows the visible count
    cfg(8'h00, 8'hf0, 8'h09);
    wait_ev(0, 300, n);
    check("count start", 32'(n >= 15 && n <= 20), 32'h1);
    $display("test rates done");
    // external input ticks; overflow reloads, flags, keeps reload
    cfg(8'h10, 8'hfe, 8'h41);
    pulses(2);
    rd("reloaded", a_cnt, 32'hff, 32'h10);
    rd("ovf flag", a_st, 32'h1, 32'h1);
    rd("reload kept", a_rld, 32'hff, 32'h10);
    apb(1'b1, a_st, 32'h1);
    rd("flag clear", a_st, 32'h1, 32'h0);
    pulses(3);
    rd("ext count", a_cnt, 32'hff, 32'h13);
    $display("test reload done");
    // gate: active-high level, then active-low with pin high
    cfg(8'h00, 8'h00, 8'h0f);
    repeat (10) @(posedge clk_sys);
    rd("gated count", a_cnt, 32'hff, 32'h0);
    rd("gated off", a_st, 32'h8, 32'h0);
    gate <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd("gated on", a_st, 32'h8, 32'h8);
    apb(1'b0, a_cnt, 32'h0);
    check("gate runs", 32'(q[7:0] != 8'h00), 32'h1);
    apb(1'b1, a_ctl, 32'h0b);
    rd("low gate off", a_st, 32'h8, 32'h0);
    $display("test gate done");
    // start bit mid period forces a full receive period
    cfg(8'h00, 8'h00, 8'h09);
    // start from a fresh rise so a natural toggle cannot pass the check
    wait_ev(3, 300, n);
    if (rx_baud !== 1'b1)
      wait_ev(3, 300, n);
    repeat (100) @(posedge clk_sys);
    fork
      i_far.start_bit(40);
    join_none
    repeat (10) @(posedge clk_sys);
    check("rx baud cleared", 32'(rx_baud), 32'h0);
    wait_ev(1, 400, n);
    check("rx realigned", 32'(n >= 240 && n <= 262), 32'h1);
    period(0, 600, n);
    check("tx untouched", 32'(n), 32'd256);
    apb(1'b1, a_ctl, 32'h0);
    repeat (2) @(posedge clk_sys);
    wait_ev(1, 600, n);
    check("rx stopped", 32'(n), 32'hffffffff);
    $display("test receive done");
    stop_test();
  end
endmodule
